// [bench/rpel_link_dev.sv]
// Link partner model: one error message per request
`timescale 1ns/1ps
`default_nettype none
module rpel_link_dev
    import rpel_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        req_i,
    input  wire logic [2:0]  kind_i,
    input  wire logic [15:0] id_i,
    output var rpel_err_t    err_o
);
    // Idle ID lines toggle, so a stale ID can never pass for a fresh one
    always_ff @(posedge mclk_i)
    begin
        err_o <= req_i ? {kind_i, id_i} : {3'h0, ~err_o.req_id};
    end
endmodule
`default_nettype wire

// [bench/rpel_logger_sva.sv]
// Checker for the logger bus slave and escalation outputs
`timescale 1ns/1ps
`default_nettype none
module rpel_logger_sva
    import rpel_pkg::*;
(
    input wire logic        mclk_i, rst_n_i, pwr_rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i,
    input wire rpel_err_t   link_err_i, int_err_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i, wb_dat_o,
    input wire logic        wb_ack_o, fatal_esc_o, nonfatal_esc_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i || !pwr_rst_n_i);
    wire logic wr = wb_ack_o && wb_we_i;
    wire logic nf = link_err_i.nonfatal || int_err_i.nonfatal;
    wire logic ft = link_err_i.fatal || int_err_i.fatal;
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
    property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("data not idle");
    property p_rdm; wb_ack_o && !wb_we_i && wb_adr_i == RPEL_STS_OFFS |-> !(|wb_dat_o[31:7]); endproperty
    a_rdm: assert property (p_rdm) else $error("upper status bits");
    property p_fset; ft |=> fatal_esc_o; endproperty
    a_fset: assert property (p_fset) else $error("fatal flag");
    property p_nset; nf |=> nonfatal_esc_o; endproperty
    a_nset: assert property (p_nset) else $error("nonfatal flag");
    property p_ffall; $fell(fatal_esc_o) |-> $past(wr); endproperty
    a_ffall: assert property (p_ffall) else $error("fatal dropped");
    property p_nfall; $fell(nonfatal_esc_o) |-> $past(wr); endproperty
    a_nfall: assert property (p_nfall) else $error("nonfatal dropped");
    property p_sev; !fatal_esc_o && nf && !ft |=> !fatal_esc_o; endproperty
    a_sev: assert property (p_sev) else $error("severity");
    c_wr: cover property (wr && wb_dat_i[6:0] != 7'h0);
    c_two: cover property (link_err_i.corr && int_err_i.corr);
    c_esc: cover property (fatal_esc_o && nonfatal_esc_o);
endmodule
bind rpel_logger rpel_logger_sva u_sva (.*);
`default_nettype wire

// [bench/tb.sv]
// Testbench for the root port error message logger
`timescale 1ns/1ps
`default_nettype none
module tb
    import rpel_pkg::*;
();
    typedef struct packed {logic [2:0] lk; logic [15:0] li; logic [2:0] ik; logic [15:0] ii;
        logic [31:0] m; logic [31:0] s; logic [31:0] d;} rpel_row_t;
    logic mclk_i = 0, rst_n_i = 0, pwr_rst_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic wb_ack_o, fatal_esc_o, nonfatal_esc_o, req = 0;
    logic [2:0] kind = '0;
    logic [15:0] id = '0;
    logic [11:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = '0, wb_dat_o, q;
    rpel_err_t link_err_i, int_err_i = '0;
    int miscompares = 0, checks = 0, cyc_n = 0;
    rpel_row_t rows [6] = '{
        '{3'h4, 16'h1111, 3'h4, 16'h2222, 32'hffff_ff80, 32'h01, 32'h0000_1111},
        '{3'h4, 16'h3333, 3'h0, 16'h0, 32'h03, 32'h03, 32'h0000_1111},
        '{3'h0, 16'h0, 3'h2, 16'h4444, 32'h0, 32'h24, 32'h4444_1111},
        '{3'h1, 16'h5555, 3'h0, 16'h0, 32'h7f, 32'h6c, 32'h4444_1111},
        '{3'h1, 16'h6666, 3'h2, 16'h7777, 32'h7f, 32'h74, 32'h6666_1111},
        '{3'h2, 16'h8888, 3'h1, 16'h9999, 32'h20, 32'h64, 32'h8888_1111}};
    always #2.5 mclk_i = ~mclk_i;
    rpel_logger dut (.mclk_i, .rst_n_i, .pwr_rst_n_i, .link_err_i, .int_err_i, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .fatal_esc_o, .nonfatal_esc_o);
    rpel_link_dev peer (.mclk_i, .req_i(req), .kind_i(kind), .id_i(id), .err_o(link_err_i));
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // Only the bench timeout ends a wait for the answer
        do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Internal error goes out one edge late to meet the partner's registered output
    task automatic inj(input rpel_row_t r);
        @(posedge mclk_i);
        req <= |r.lk;
        kind <= r.lk;
        id <= r.li;
        @(posedge mclk_i);
        req <= 1'b0;
        int_err_i <= {r.ik, r.ii};
        @(posedge mclk_i);
        int_err_i <= {3'h0, ~r.ii};
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk_i)
    begin
        cyc_n++;
        if (cyc_n == 3000)
        begin
            miscompares++;
            summarize();
        end
    end
    initial
    begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        pwr_rst_n_i <= 1'b1;
        bus(1'b0, RPEL_STS_OFFS, 32'h0);
        chk(32'h0, q);
        foreach (rows[i])
        begin
            inj(rows[i]);
            bus(1'b0, RPEL_STS_OFFS, 32'h0);
            chk(rows[i].s, q);
            bus(1'b0, RPEL_SID_OFFS, 32'h0);
            chk(rows[i].d, q);
            bus(1'b1, RPEL_STS_OFFS, rows[i].m);
            $display("row %0d done", i);
        end
        rst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        bus(1'b0, RPEL_STS_OFFS, 32'h0);
        chk(32'h44, q);
        chk(32'h3, {30'h0, fatal_esc_o, nonfatal_esc_o});
        bus(1'b1, RPEL_SID_OFFS, 32'hffff_ffff);
        bus(1'b0, RPEL_SID_OFFS, 32'h0);
        chk(32'h8888_1111, q);
        bus(1'b0, 12'h138, 32'h0);
        chk(32'h0, q);
        $display("sticky and map tests done");
        summarize();
    end
endmodule
`default_nettype wire

// [hw/rpel_logger.sv]
// Root port error message status and source ID logger with Wishbone slave
//
// Behaviour
// - An arriving error sets its class first flag and logs requestor ID.
// - Writing one clears a status flag; writing zero leaves it alone.
// - Repeat error while first flag set sets multiple flag, ID kept.
// - Read-only five-bit interrupt message number field, resets to zero.
// - Bit 6 sets on any fatal message and holds until written one.
// - Bits 6, 4 and 2 decide when fatal escalation clears.
// - Bit 5 sets on any non-fatal message and holds until written one.
// - Bits 5, 4 and 2 decide when non-fatal escalation clears.
// - Bit 4 holds first uncorrectable severity: one fatal, zero non-fatal.
// - Bit 3 sets on uncorrectable error while bit 2 already set.
// - Two uncorrectable first errors together set bit 2 but not bit 3.
// - Bit 2 sets on the first fatal or non-fatal error.
// - Bit 1 sets on correctable error while bit 0 already set.
// - Two correctable first errors together set only bit 0.
// - Bit 0 sets on the first correctable error.
// - Upper ID half logs uncorrectable source only while bit 2 clear.
// - Lower ID half logs correctable source only while bit 0 clear.
// - Link error ID wins over internal error ID in the same clock.
// - Flags and IDs survive system reset; only power-up clears them.
`timescale 1ns/1ps
`default_nettype none
module rpel_logger
    import rpel_pkg::*;
#(
    parameter logic [4:0] MSG_NUM = RPEL_MSG_RST
)(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        pwr_rst_n_i,
    input  wire rpel_err_t   link_err_i,
    input  wire rpel_err_t   int_err_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             fatal_esc_o,
    output logic             nonfatal_esc_o
);
    rpel_sticky_t st_q;
    rpel_sticky_t st_d;
    rpel_bus_t    bus_q;
    rpel_bus_t    bus_d;

    logic [31:0] sts_word;
    logic [31:0] sid_word;
    logic [31:0] be_mask;
    logic [6:0]  clr;
    logic [6:0]  set;
    logic [6:0]  nsts;
    logic        any_cor;
    logic        any_unc;
    logic        any_fat;
    logic        any_nf;
    logic        first_fatal;
    logic [15:0] unc_src;
    logic [15:0] cor_src;
    logic        wr_sts;
    logic        lnk_unc;

    // Reserved bits read zero message number is fixed
    assign sts_word = {MSG_NUM, 20'h0_0000, st_q.sts};
    assign sid_word = {st_q.unc_id, st_q.cor_id};
    assign be_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb
    begin
        st_d     = st_q;
        any_cor  = link_err_i.corr | int_err_i.corr;
        any_fat  = link_err_i.fatal | int_err_i.fatal;
        any_nf   = link_err_i.nonfatal | int_err_i.nonfatal;
        any_unc  = any_fat | any_nf;
        lnk_unc  = link_err_i.fatal | link_err_i.nonfatal;
        // Link source has priority for the logged ID and severity
        unc_src  = lnk_unc ? link_err_i.req_id : int_err_i.req_id;
        cor_src  = link_err_i.corr ? link_err_i.req_id : int_err_i.req_id;
        first_fatal = lnk_unc ? link_err_i.fatal : int_err_i.fatal;
        // Write takes effect at the edge where ack is seen
        wr_sts   = wb_cyc_i & wb_stb_i & wb_we_i & bus_q.ack
                   & (wb_adr_i == RPEL_STS_OFFS);
        clr      = wr_sts ? (wb_dat_i[6:0] & be_mask[6:0]) : 7'h00;
        set      = 7'h00;
        set[RPEL_FC_BIT] = any_cor;
        set[RPEL_MC_BIT] = any_cor & st_q.sts[RPEL_FC_BIT];
        set[RPEL_FU_BIT] = any_unc;
        set[RPEL_MU_BIT] = any_unc & st_q.sts[RPEL_FU_BIT];
        set[RPEL_FF_BIT] = any_unc & ~st_q.sts[RPEL_FU_BIT] & first_fatal;
        set[RPEL_FD_BIT] = any_fat;
        set[RPEL_NF_BIT] = any_nf;
        // Set wins over a same-cycle clear so no event is lost
        nsts = (st_q.sts & ~clr) | set;
        // A non-fatal first error forces severity to zero even if bit 4 stale
        if (any_unc & ~st_q.sts[RPEL_FU_BIT] & ~first_fatal)
        begin
            nsts[RPEL_FF_BIT] = 1'b0;
        end
        st_d.sts = nsts;
        if (any_unc & ~st_q.sts[RPEL_FU_BIT])
        begin
            st_d.unc_id = unc_src;
        end
        if (any_cor & ~st_q.sts[RPEL_FC_BIT])
        begin
            st_d.cor_id = cor_src;
        end
        // Escalation holds while its detect bit is set, or while bit 2 is set and bit 4 gives its severity
        st_d.fatal_esc    = nsts[RPEL_FD_BIT]
                            | (nsts[RPEL_FU_BIT] & nsts[RPEL_FF_BIT]);
        st_d.nonfatal_esc = nsts[RPEL_NF_BIT]
                            | (nsts[RPEL_FU_BIT] & ~nsts[RPEL_FF_BIT]);

        // Single-wait-state slave; unmapped addresses ack with zero data
        bus_d     = bus_q;
        bus_d.ack = wb_cyc_i & wb_stb_i & ~bus_q.ack;
        bus_d.dat = RPEL_DAT_RST;
        if (wb_cyc_i & wb_stb_i & ~bus_q.ack & ~wb_we_i)
        begin
            case (wb_adr_i)
                RPEL_STS_OFFS: bus_d.dat = sts_word;
                RPEL_SID_OFFS: bus_d.dat = sid_word;
                default:       bus_d.dat = RPEL_DAT_RST;
            endcase
        end
    end

    // Sticky state sees only power-up reset, not system reset
    always_ff @(posedge mclk_i or negedge pwr_rst_n_i)
    begin
        if (!pwr_rst_n_i)
        begin
            st_q <= '{sts: RPEL_STS_RST, unc_id: RPEL_ID_RST,
                      cor_id: RPEL_ID_RST, fatal_esc: 1'b0,
                      nonfatal_esc: 1'b0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bus_q <= '{ack: 1'b0, dat: RPEL_DAT_RST};
        end
        else
        begin
            bus_q <= bus_d;
        end
    end

    assign wb_ack_o       = bus_q.ack;
    assign wb_dat_o       = bus_q.dat;
    assign fatal_esc_o    = st_q.fatal_esc;
    assign nonfatal_esc_o = st_q.nonfatal_esc;
endmodule
`default_nettype wire

// [hw/rpel_pkg.sv]
// Package for the root port error message logger: map, fields, carriers
package rpel_pkg;
    localparam logic [11:0] RPEL_STS_OFFS  = 12'h130;
    localparam logic [11:0] RPEL_SID_OFFS  = 12'h134;
    localparam int          RPEL_FC_BIT    = 0;
    localparam int          RPEL_MC_BIT    = 1;
    localparam int          RPEL_FU_BIT    = 2;
    localparam int          RPEL_MU_BIT    = 3;
    localparam int          RPEL_FF_BIT    = 4;
    localparam int          RPEL_NF_BIT    = 5;
    localparam int          RPEL_FD_BIT    = 6;
    localparam int          RPEL_MSG_LSB   = 27;
    localparam logic [6:0]  RPEL_STS_RST   = 7'h00;
    localparam logic [15:0] RPEL_ID_RST    = 16'h0000;
    localparam logic [4:0]  RPEL_MSG_RST   = 5'h00;
    localparam logic [31:0] RPEL_DAT_RST   = 32'h0000_0000;

    // One error report from a source: class strobes and requestor ID
    typedef struct packed {
        logic        corr;
        logic        nonfatal;
        logic        fatal;
        logic [15:0] req_id;
    } rpel_err_t;

    // State that survives system reset
    typedef struct packed {
        logic [6:0]  sts;
        logic [15:0] unc_id;
        logic [15:0] cor_id;
        logic        fatal_esc;
        logic        nonfatal_esc;
    } rpel_sticky_t;

    // Bus slave state, cleared by system reset
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } rpel_bus_t;
endpackage
